// ### rtl/fetx_buf.sv
// fetx_buf: small valid/ready buffer in the nibble path
`timescale 1ns/1ps
module fetx_buf
  import fetx_pkg::*;
#(
  parameter int WIDTH = 6,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic full_reg, full_next, ready_reg, ready_next;
  logic push, pop;

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  always_comb
  begin
    push = i_in_valid && !full_reg;
    pop = i_out_ready && (cnt_reg != '0);
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push)
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    if (pop)
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    full_next = (cnt_next == CW'(DEPTH));
    ready_next = !full_next;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
      ready_reg <= 1'b1;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
      ready_reg <= ready_next;
    end
  end

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_reg[wr_reg] <= i_in_data;
  end

  // ready comes straight from its own flop, no gate after it
  assign o_in_ready = ready_reg;
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];

endmodule : fetx_buf

// ### rtl/fetx_encoder.sv
// fetx_encoder: 100 Mb/s transmit code-group encoder top
`timescale 1ns/1ps
module fetx_encoder
  import fetx_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // nibble stream from the mac
  input wire logic i_nib_valid,
  input wire fetx_nib_type i_nib,
  output logic o_nib_ready,
  // straps and mode pins
  input wire logic [4:0] i_phy_address_straps,
  input wire logic i_scr_bypass,
  // line driver phases
  output logic o_mlt_pos,
  output logic o_mlt_neg,
  // status
  output logic o_tx_busy
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] strap_meta_reg, strap_sync_reg;
  logic byp_meta_reg, byp_sync_reg;

  // straps and bypass arrive from pins, two flops each
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_meta_reg <= 5'h00;
      strap_sync_reg <= 5'h00;
      byp_meta_reg <= 1'b0;
      byp_sync_reg <= 1'b0;
    end
    else
    begin
      strap_meta_reg <= i_phy_address_straps;
      strap_sync_reg <= strap_meta_reg;
      byp_meta_reg <= i_scr_bypass;
      byp_sync_reg <= byp_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // symbol-rate enable
  // ----------------------------------------------------------------
  logic [2:0] acc_reg, acc_next;
  logic sym_en_reg, sym_en_next;

  // fractional divider: 5 of every 8 clocks carry a symbol
  always_comb
  begin
    {sym_en_next, acc_next} = {1'b0, acc_reg} + FETX_ACC_STEP;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_reg <= 3'h0;
      sym_en_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      sym_en_reg <= sym_en_next;
    end
  end

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  logic buf_valid, buf_take;
  logic [$bits(fetx_nib_type)-1:0] buf_data;
  fetx_nib_type buf_nib;

  // a stalled slot never drops a nibble; the mac sees ready low
  fetx_buf #(
    .WIDTH($bits(fetx_nib_type)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(i_nib_valid),
    .i_in_data(i_nib),
    .o_in_ready(o_nib_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(buf_take)
  );

  assign buf_nib = fetx_nib_type'(buf_data);

  // ----------------------------------------------------------------
  // framing state machine and serializer
  // ----------------------------------------------------------------
  fetx_state_type st_reg, st_next;
  logic [4:0] sh_reg, sh_next;
  logic [2:0] cnt_reg, cnt_next;
  logic busy_next;
  logic load;
  logic [4:0] cg;

  // code-group choice at each nibble boundary
  always_comb
  begin
    load = sym_en_reg && (cnt_reg == FETX_BIT_LAST);
    buf_take = 1'b0;
    st_next = st_reg;
    cg = FETX_CG_I;
    if (load)
    begin
      unique case (st_reg)
        FETX_IDLE:
        begin
          // slots with enable low are idle slots
          buf_take = buf_valid;
          if (buf_valid && buf_nib.en)
          begin
            cg = FETX_CG_J;
            st_next = FETX_SEND_K;
          end
        end
        FETX_SEND_K:
        begin
          buf_take = buf_valid && buf_nib.en;
          cg = FETX_CG_K;
          st_next = FETX_DATA;
        end
        FETX_DATA:
        begin
          buf_take = buf_valid;
          if (buf_valid && buf_nib.en)
          begin
            if (buf_nib.er)
              cg = FETX_CG_H;
            else
              cg = fetx_enc(buf_nib.data);
          end
          else
          begin
            cg = FETX_CG_T;
            st_next = FETX_END_R;
          end
        end
        FETX_END_R:
        begin
          cg = FETX_CG_R;
          st_next = FETX_IDLE;
        end
      endcase
    end
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    if (load)
    begin
      sh_next = cg;
      cnt_next = 3'h0;
    end
    else if (sym_en_reg)
    begin
      // first bit sent is the leftmost of the code-group
      sh_next = {sh_reg[3:0], 1'b0};
      cnt_next = cnt_reg + 3'h1;
    end
    busy_next = (st_next != FETX_IDLE);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= FETX_IDLE;
      sh_reg <= FETX_CG_I;
      cnt_reg <= FETX_BIT_LAST;
      o_tx_busy <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      o_tx_busy <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // scrambler and line coder
  // ----------------------------------------------------------------
  // mlt-3 only, no binary mode
  fetx_line u_line (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_bit_en(sym_en_reg),
    .i_bit(sh_reg[4]),
    .i_seed(strap_sync_reg),
    .i_bypass(byp_sync_reg),
    .o_pos(o_mlt_pos),
    .o_neg(o_mlt_neg)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_data_map;
    @(posedge i_clock) disable iff (i_rst)
    (load && st_reg == FETX_DATA && buf_valid && buf_nib.en
      && !buf_nib.er) |=> sh_reg == fetx_enc($past(buf_nib.data));
  endproperty
  a_data_map: assert property (p_data_map)
    else $error("data nibble sent with wrong code-group");

  property p_start_jk;
    @(posedge i_clock) disable iff (i_rst)
    (load && st_reg == FETX_IDLE && buf_valid && buf_nib.en)
      |=> sh_reg == FETX_CG_J ##[5:8] sh_reg == FETX_CG_K;
  endproperty
  a_start_jk: assert property (p_start_jk)
    else $error("start delimiter not J then K");

  property p_end_tr;
    @(posedge i_clock) disable iff (i_rst)
    (load && st_reg == FETX_DATA && !(buf_valid && buf_nib.en))
      |=> sh_reg == FETX_CG_T ##[5:8] sh_reg == FETX_CG_R;
  endproperty
  a_end_tr: assert property (p_end_tr)
    else $error("end delimiter not T then R");

  property p_idle_fill;
    @(posedge i_clock) disable iff (i_rst)
    (load && st_reg == FETX_IDLE && !(buf_valid && buf_nib.en))
      |=> sh_reg == FETX_CG_I;
  endproperty
  a_idle_fill: assert property (p_idle_fill)
    else $error("gap not filled with idle");

  property p_halt;
    @(posedge i_clock) disable iff (i_rst)
    (load && st_reg == FETX_DATA && buf_valid && buf_nib.en
      && buf_nib.er) |=> sh_reg == FETX_CG_H;
  endproperty
  a_halt: assert property (p_halt)
    else $error("error slot did not send halt");

  property p_rate;
    @(posedge i_clock) disable iff (i_rst)
    sym_en_reg |-> ##8 sym_en_reg;
  endproperty
  a_rate: assert property (p_rate)
    else $error("symbol enable pattern broken");

  property p_frame_order;
    @(posedge i_clock) disable iff (i_rst)
    (st_reg == FETX_END_R && load) |=> st_reg == FETX_IDLE;
  endproperty
  a_frame_order: assert property (p_frame_order)
    else $error("state after R is not idle");

  c_frame_start: cover property (@(posedge i_clock) disable iff (i_rst)
    st_reg == FETX_IDLE ##1 st_reg == FETX_SEND_K);
  c_halt_sent: cover property (@(posedge i_clock) disable iff (i_rst)
    sh_reg == FETX_CG_H);
  c_frame_end: cover property (@(posedge i_clock) disable iff (i_rst)
    st_reg == FETX_END_R ##[1:8] st_reg == FETX_IDLE);
  c_stall: cover property (@(posedge i_clock) disable iff (i_rst)
    i_nib_valid && !o_nib_ready);

endmodule : fetx_encoder

// ### rtl/fetx_line.sv
// fetx_line: scrambler, nrzi encoder and mlt-3 phase outputs
`timescale 1ns/1ps
module fetx_line
  import fetx_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // serial code bits
  input wire logic i_bit_en,
  input wire logic i_bit,
  input wire logic [4:0] i_seed,
  input wire logic i_bypass,
  // line driver phases
  output logic o_pos,
  output logic o_neg
);
  logic [10:0] lfsr_reg, lfsr_next;
  logic [1:0] wait_reg, wait_next;
  logic nrzi_reg, nrzi_next, pos_next, neg_next;
  logic [1:0] phase_reg, phase_next;
  logic fb, scr;

  // ----------------------------------------------------------------
  // scrambler, nrzi and mlt-3 next state
  // ----------------------------------------------------------------
  always_comb
  begin
    fb = lfsr_reg[10] ^ lfsr_reg[8];
    scr = i_bit ^ (fb & !i_bypass);
    lfsr_next = lfsr_reg;
    wait_next = wait_reg;
    nrzi_next = nrzi_reg;
    phase_next = phase_reg;
    if (wait_reg != FETX_SEED_WAIT)
    begin
      // straps settle through the synchroniser first
      wait_next = wait_reg + 2'h1;
      lfsr_next = {FETX_SEED_PAD, i_seed};
    end
    else if (i_bit_en)
    begin
      lfsr_next = {lfsr_reg[9:0], fb};
      nrzi_next = nrzi_reg ^ scr;
      if (nrzi_next != nrzi_reg)
        phase_next = phase_reg + 2'h1;
    end
    pos_next = (phase_next == 2'h1);
    neg_next = (phase_next == 2'h3);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      lfsr_reg <= {FETX_SEED_PAD, 5'h00};
      wait_reg <= 2'h0;
      nrzi_reg <= 1'b0;
      phase_reg <= 2'h0;
      o_pos <= 1'b0;
      o_neg <= 1'b0;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
      wait_reg <= wait_next;
      nrzi_reg <= nrzi_next;
      phase_reg <= phase_next;
      o_pos <= pos_next;
      o_neg <= neg_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_nrzi_toggle;
    @(posedge i_clock) disable iff (i_rst)
    (i_bit_en && wait_reg == FETX_SEED_WAIT)
      |=> (nrzi_reg != $past(nrzi_reg)) == $past(scr);
  endproperty
  a_nrzi_toggle: assert property (p_nrzi_toggle)
    else $error("nrzi did not follow the scrambled bit");

  property p_bypass;
    @(posedge i_clock) disable iff (i_rst)
    i_bypass |-> scr == i_bit;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass still scrambles");

  property p_lfsr_live;
    @(posedge i_clock) disable iff (i_rst)
    lfsr_reg != 11'h000;
  endproperty
  a_lfsr_live: assert property (p_lfsr_live)
    else $error("scrambler locked at zero");

  property p_mlt_step;
    @(posedge i_clock) disable iff (i_rst)
    (i_bit_en && wait_reg == FETX_SEED_WAIT && scr && !o_pos && !o_neg
      && phase_reg == 2'h0) |=> o_pos ##0 !o_neg;
  endproperty
  a_mlt_step: assert property (p_mlt_step)
    else $error("mlt-3 missed the step to plus");

  property p_mlt_excl;
    @(posedge i_clock) disable iff (i_rst)
    !(o_pos && o_neg);
  endproperty
  a_mlt_excl: assert property (p_mlt_excl)
    else $error("both line phases driven");

endmodule : fetx_line

// ### rtl/fetx_pkg.sv
// fetx_pkg: constants, types and 4b/5b table of the tx encoder
package fetx_pkg;

  // ----------------------------------------------------------------
  // control code-groups
  // ----------------------------------------------------------------
  localparam logic [4:0] FETX_CG_J = 5'h18;
  localparam logic [4:0] FETX_CG_K = 5'h11;
  localparam logic [4:0] FETX_CG_T = 5'h0d;
  localparam logic [4:0] FETX_CG_R = 5'h07;
  localparam logic [4:0] FETX_CG_I = 5'h1f;
  localparam logic [4:0] FETX_CG_H = 5'h04;

  // ----------------------------------------------------------------
  // timing: symbol rate enable from a 3-bit phase accumulator
  // ----------------------------------------------------------------
  localparam int FETX_CLK_MHZ = 200;
  localparam int FETX_SYM_MBPS = 125;
  localparam int FETX_ACC_BITS = 3;
  localparam logic [3:0] FETX_ACC_STEP =
    4'(FETX_SYM_MBPS * (2 ** FETX_ACC_BITS) / FETX_CLK_MHZ);
  localparam logic [2:0] FETX_BIT_LAST = 3'h4;
  localparam logic [1:0] FETX_SEED_WAIT = 2'h3;

  // ----------------------------------------------------------------
  // scrambler seed: pad bits keep the seed nonzero
  // ----------------------------------------------------------------
  localparam logic [5:0] FETX_SEED_PAD = 6'h2a;

  typedef enum logic [1:0] {
    FETX_IDLE = 2'h0,
    FETX_SEND_K = 2'h1,
    FETX_DATA = 2'h3,
    FETX_END_R = 2'h2
  } fetx_state_type;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] data;
  } fetx_nib_type;

  // 4b to 5b data code-group
  function automatic logic [4:0] fetx_enc(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1e;
    unique case (nib)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      4'hf: cg = 5'h1d;
    endcase
    return cg;
  endfunction : fetx_enc

endpackage : fetx_pkg

// ### verification/fetx_encoder_tb.sv
// fetx_encoder_tb: self-checking bench for the tx code-group encoder
`timescale 1ns/1ps
module fetx_encoder_tb;
  import fetx_pkg::*;
  logic i_clock;
  logic i_rst;
  logic i_nib_valid;
  fetx_nib_type i_nib;
  logic o_nib_ready;
  logic [4:0] i_phy_address_straps;
  logic i_scr_bypass;
  logic o_mlt_pos;
  logic o_mlt_neg;
  logic o_tx_busy;
  int fail_count = 0;
  int cmp_count = 0;
  logic [4:0] exp_q [$];
  logic [4:0] dat_tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic [7:0] ph_mask = '0;
  logic learn = 1'b0;
  logic dec_on = 1'b0;
  logic [63:0] win;
  logic [9:0] sh;
  logic bt;
  logic in_frm;
  int lv;
  int lv_prev;
  int lv_nz;
  int cyc;
  int nbit;
  int idl;

  // ----------------------------------------------------------------
  // design, far side and clock
  // ----------------------------------------------------------------
  fetx_encoder DUT (.i_clock(i_clock), .i_rst(i_rst),
    .i_nib_valid(i_nib_valid), .i_nib(i_nib), .o_nib_ready(o_nib_ready),
    .i_phy_address_straps(i_phy_address_straps),
    .i_scr_bypass(i_scr_bypass), .o_mlt_pos(o_mlt_pos),
    .o_mlt_neg(o_mlt_neg), .o_tx_busy(o_tx_busy));
  fetx_mac MAC (.i_clock(i_clock), .o_nib_valid(i_nib_valid),
    .o_nib(i_nib), .i_nib_ready(o_nib_ready));

  // 200 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // inputs always move 1 ns after an edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_clk

  // oldest note; empty queue gives x so it never matches
  function automatic logic [4:0] nxt();
    if (exp_q.size() == 0)
      return 'x;
    return exp_q.pop_front();
  endfunction : nxt

  // one frame: notes expected code-groups, then feeds the mac model
  task automatic frame(input int n, input logic all16);
    fetx_nib_type s;
    s = '{en: 1'b1, er: 1'b0, data: 4'h5};
    exp_q.push_back(5'h18);
    exp_q.push_back(5'h11);
    MAC.send(s);
    // n below zero: enable drops right after the first preamble slot
    if (n >= 0)
      MAC.send(s);
    for (int i = 0; i < n; i++)
    begin
      s.data = all16 ? 4'(i) : 4'($urandom);
      s.er = !all16 && (i == 0 || $urandom % 6 == 0);
      exp_q.push_back(s.er ? 5'h04 : dat_tbl[s.data]);
      MAC.send(s);
    end
    exp_q.push_back(5'h0d);
    exp_q.push_back(5'h07);
    MAC.finish();
    wait_clk(12);
    check("busy", 32'(o_tx_busy), 1);
    wait_clk(120);
    check("busy idle", 32'(o_tx_busy), 0);
  endtask : frame

  // aligned decoder: j/k pair sets the code-group boundary
  task automatic decode();
    logic [4:0] e;
    if (!in_frm && sh == 10'h311)
    begin
      in_frm = 1'b1;
      nbit = 0;
      check("start j", 32'(sh[9:5]), 32'(nxt()));
      check("start k", 32'(sh[4:0]), 32'(nxt()));
    end
    else if (nbit == 5)
    begin
      nbit = 0;
      if (in_frm)
      begin
        e = nxt();
        check("code", 32'(sh[4:0]), 32'(e));
        in_frm = (e !== 5'h07);
        idl = in_frm ? 0 : 3;
      end
      else if (idl > 0)
      begin
        idl--;
        check("idle", 32'(sh[4:0]), 32'h1f);
      end
    end
  endtask : decode

  // line monitor: a level change at a symbol phase is a one
  // sampled on the falling edge, where the line outputs are settled
  always @(negedge i_clock)
  begin
    lv = o_mlt_pos ? 1 : (o_mlt_neg ? -1 : 0);
    bt = (lv != lv_prev);
    if (i_rst)
    begin
      cyc = 0;
      lv_prev = 0;
      lv_nz = 0;
      in_frm = 1'b0;
      nbit = 0;
      idl = 0;
    end
    else
    begin
      if (bt)
      begin
        check("both phases", 32'(o_mlt_pos & o_mlt_neg), 0);
        check("mlt step", 32'((lv == 0 || lv_prev == 0) &&
          (lv == 0 || lv_nz == 0 || lv == -lv_nz)), 1);
        if (lv != 0)
          lv_nz = lv;
      end
      lv_prev = lv;
      if (learn)
        ph_mask[cyc % 8] = ph_mask[cyc % 8] | bt;
      else if (ph_mask[cyc % 8])
      begin
        win = {win[62:0], bt};
        sh = {sh[8:0], bt};
        nbit++;
        if (dec_on)
          decode();
      end
      cyc++;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int bad;
    logic [63:0] wk [2];
    logic [4:0] st;
    void'($urandom(36027));
    st = 5'($urandom);
    i_rst = 1'b1;
    i_scr_bypass = 1'b1;
    i_phy_address_straps = st;
    repeat (6) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    // unscrambled idle toggles on every symbol: learn the phases
    wait_clk(40);
    learn = 1'b1;
    wait_clk(64);
    learn = 1'b0;
    check("symbol phases", 32'($countones(ph_mask)), 5);
    dec_on = 1'b1;
    frame(18, 1'b1);
    check("stall", 32'(MAC.saw_stall), 1);
    frame(0, 1'b0);
    frame(-1, 1'b0);
    for (int k = 0; k < 4; k++)
      frame(1 + int'($urandom % 12), 1'b0);
    check("notes left", 32'(exp_q.size()), 0);
    dec_on = 1'b0;
    // scrambled idle must obey n(t) = 1 ^ n(t-11) ^ n(t-9)
    i_scr_bypass = 1'b0;
    wait_clk(200);
    bad = 0;
    for (int j = 0; j < 53; j++)
      bad += (win[j] ^ win[j + 9] ^ win[j + 11]) ? 0 : 1;
    check("lfsr", 32'(bad), 0);
    check("scrambled", 32'(win != '1), 1);
    // two strap values, same reset timing, must give two sequences
    for (int k = 0; k < 2; k++)
    begin
      i_phy_address_straps = k ? ~st : st;
      i_rst = 1'b1;
      wait_clk(3);
      i_rst = 1'b0;
      wait_clk(200);
      wk[k] = win;
    end
    check("seed", 32'(wk[0] != wk[1]), 1);
    give_verdict();
  end

  // watchdog: the run needs about 2000 clocks, allow ten times that
  initial
  begin
    #100us;
    fail_count++;
    give_verdict();
  end
endmodule : fetx_encoder_tb

// ### verification/fetx_mac.sv
// fetx_mac: behavioural nibble source standing in for the mac
`timescale 1ns/1ps
module fetx_mac
  import fetx_pkg::*;
(
  // clock
  input wire logic i_clock,
  // nibble stream towards the encoder
  output logic o_nib_valid,
  output fetx_nib_type o_nib,
  input wire logic i_nib_ready
);
  logic saw_stall;

  // quiet start, nothing offered
  initial
  begin
    o_nib_valid = 1'b0;
    o_nib = '0;
    saw_stall = 1'b0;
  end

  // offer one slot, hold it until the edge that takes it
  task automatic send(input fetx_nib_type s);
    o_nib_valid = 1'b1;
    o_nib = s;
    @(posedge i_clock);
    while (i_nib_ready !== 1'b1)
    begin
      saw_stall = 1'b1; // buffer full, keep holding
      @(posedge i_clock);
    end
    #1;
  endtask : send

  task automatic finish();
    send('{en: 1'b0, er: 1'b0, data: 4'h0});
    o_nib_valid = 1'b0;
    // released lines must not look like the last slot
    o_nib = fetx_nib_type'(~o_nib);
  endtask : finish
endmodule : fetx_mac
